// File: src/dmcd_decode.sv
// Command decode, mode register loads and burst address sequencing
`timescale 1ns/1ps
// Functional notes
// - Load-mode bank bits 00 pick base register, 01 extended, others reserved.
// - Op-code comes from address bits 0..11 or 0..12 depending on density.
// - Operating-mode bits 7 upward all zero selects normal operation.
// - Bit 8 alone set starts DLL reset; stored bit 8 clears itself.
// - Extended register holds DLL enable and drive strength until rewritten.
// - Leaving self refresh re-enables the DLL without a register write.
// - Chip select high and the no-operation code behave identically.
// - Row, column and write strobes decode into the seven commands.
// - Column from bits 0..9 plus bit 11; bit 10 asks auto precharge.
// - Precharge with bit 10 high closes all banks, else addressed bank.
// - Refresh code: auto refresh with clock enable high, self refresh low.
// - A high write mask level blocks its data from being written.
// - Burst covers aligned block; low column bits pick the first word.
// - Burst wraps inside its aligned block at the boundary.
// - Sequential order adds count modulo length; interleaved XORs it.
// - Latency codes 010 is two clocks, 110 is 2.5; rest reserved.
// - Mode bits 0..2 give burst length, bit 3 type, for reads and writes.
// - A read at edge n gives its first data at edge n plus latency.
module dmcd_decode #(
  parameter bit COL_HI_EN = 1'b1
) (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          link_clk,
  input  wire logic                          chip_sel_n,
  input  wire logic                          row_strobe_n,
  input  wire logic                          col_strobe_n,
  input  wire logic                          write_en_n,
  input  wire logic                          clk_en,
  input  wire logic                          bank_sel_lo,
  input  wire logic                          bank_sel_hi,
  input  wire logic [dmcd_pkg::ADDR_W-1:0]   addr,
  input  wire logic [dmcd_pkg::DATA_W-1:0]   wr_data,
  input  wire logic [dmcd_pkg::MASK_W-1:0]   write_mask,
  input  wire logic                          mem_wr_ready,
  output logic [dmcd_pkg::ADDR_W-1:0]        mode_reg,
  output logic [dmcd_pkg::ADDR_W-1:0]        ext_mode_reg,
  output logic                               dll_enabled,
  output logic                               dll_reset_pulse,
  output logic                               drive_reduced,
  output logic [3:0]                         bank_open,
  output logic                               auto_refresh_pulse,
  output logic                               self_refresh,
  output logic                               rd_beat,
  output logic                               rd_half_clk,
  output logic [1:0]                         rd_bank,
  output logic [dmcd_pkg::COL_W-1:0]         rd_col,
  output logic                               wr_buf_ready,
  output logic                               wr_beat_lost,
  output logic                               mem_wr_valid,
  output logic [1:0]                         mem_wr_bank,
  output logic [dmcd_pkg::COL_W-1:0]         mem_wr_col,
  output logic [dmcd_pkg::MASK_W-1:0]        mem_wr_byte_en,
  output logic [dmcd_pkg::DATA_W-1:0]        mem_wr_data
);
  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                           ck_s1;
    logic                           ck_s2;
    logic                           ck_s3;
    dmcd_pkg::dmcd_pins_t           pin_s1;
    dmcd_pkg::dmcd_pins_t           pin_s2;
    logic [dmcd_pkg::ADDR_W-1:0]    mode;
    logic [dmcd_pkg::ADDR_W-1:0]    ext;
    logic                           dll_on;
    logic                           dll_rst;
    logic [3:0]                     banks;
    logic                           aref;
    logic                           sref;
    dmcd_pkg::dmcd_bst_t            bst;
    logic                           b_wr;
    logic                           b_ap;
    logic [1:0]                     b_bank;
    logic [dmcd_pkg::COL_W-1:0]     b_col;
    logic [2:0]                     b_cnt;
    logic [2:0]                     b_lm1;
    logic [1:0]                     b_wait;
    logic                           rd_v;
    logic                           rd_h;
    logic [1:0]                     rd_bk;
    logic [dmcd_pkg::COL_W-1:0]     rd_c;
    logic                           push_v;
    logic [dmcd_pkg::WORD_W-1:0]    push_w;
    logic                           lost;
    logic                           buf_rdy;
    logic                           out_v;
    logic [dmcd_pkg::WORD_W-1:0]    out_w;
  } dmcd_st_t;

  dmcd_st_t             s_q;
  dmcd_st_t             s_d;
  dmcd_pkg::dmcd_pins_t pins;
  dmcd_pkg::dmcd_cmd_t  cmd;
  logic                 rise;
  logic [5:0]           opm;
  logic [dmcd_pkg::COL_W-1:0] col_in;
  logic [2:0]           bl_m1;
  logic                 lat_ok;
  logic                 beat;

  dmcd_word_if wr_in ();
  dmcd_word_if wr_out ();

  dmcd_fifo #(.W(dmcd_pkg::WORD_W), .DEPTH(dmcd_pkg::FIFO_DEPTH)) u_buf (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .fill    (wr_in),
    .drain   (wr_out)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Length field to last-beat index; zero marks a reserved length
  function automatic logic [2:0] bl_decode(input logic [2:0] f);
    case (f)
      dmcd_pkg::BL_TWO:   bl_decode = 3'h1;
      dmcd_pkg::BL_FOUR:  bl_decode = 3'h3;
      dmcd_pkg::BL_EIGHT: bl_decode = 3'h7;
      default:            bl_decode = 3'h0;
    endcase
  endfunction

  // Column of beat cnt inside the aligned block of the start column
  function automatic logic [dmcd_pkg::COL_W-1:0] burst_col(
      input logic [dmcd_pkg::COL_W-1:0] start, input logic [2:0] cnt,
      input logic [2:0] lm1, input logic ilv);
    logic [2:0] off;
    off = ilv ? (start[2:0] ^ cnt) : (start[2:0] + cnt);
    off = off & lm1;
    burst_col = (start & ~{8'h00, lm1}) | {8'h00, off};
  endfunction

  // ----------------------------------------------------------------
  // Sampled pins and decode of the strobes
  // ----------------------------------------------------------------
  assign pins  = s_q.pin_s2;
  assign rise  = s_q.ck_s2 & ~s_q.ck_s3;
  assign opm   = pins.addr[dmcd_pkg::ADDR_W-1:dmcd_pkg::OPMODE_LO];
  assign bl_m1 = bl_decode(s_q.mode[2:0]);
  assign lat_ok = (s_q.mode[6:4] == dmcd_pkg::LAT_TWO) || (s_q.mode[6:4] == dmcd_pkg::LAT_TWO_H);
  assign col_in = {COL_HI_EN & pins.addr[dmcd_pkg::COL_HI_POS], pins.addr[9:0]};

  // Deselect folds onto the no-operation code
  always_comb begin
    if (pins.cs_n) begin
      cmd = dmcd_pkg::DMCD_NO_OP;
    end else begin
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'h3:    cmd = dmcd_pkg::DMCD_ACT;
        3'h5:    cmd = dmcd_pkg::DMCD_RD;
        3'h4:    cmd = dmcd_pkg::DMCD_WR;
        3'h6:    cmd = dmcd_pkg::DMCD_STOP;
        3'h2:    cmd = dmcd_pkg::DMCD_PRE;
        3'h1:    cmd = dmcd_pkg::DMCD_REF;
        3'h0:    cmd = dmcd_pkg::DMCD_LMR;
        default: cmd = dmcd_pkg::DMCD_NO_OP;
      endcase
    end
  end

  // Beat emitted at this link edge
  assign beat = rise && ((s_q.bst == dmcd_pkg::BST_RUN) ||
                         (s_q.bst == dmcd_pkg::BST_WAIT && s_q.b_wait == 2'h1));

  // Buffer hookup; output stage refills when empty or taken
  assign wr_in.valid  = s_q.push_v;
  assign wr_in.data   = s_q.push_w;
  assign wr_out.ready = ~s_q.out_v | mem_wr_ready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.ck_s1   = link_clk;
    s_d.ck_s2   = s_q.ck_s1;
    s_d.ck_s3   = s_q.ck_s2;
    s_d.pin_s1  = {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, clk_en,
                   bank_sel_hi, bank_sel_lo, addr, wr_data, write_mask};
    s_d.pin_s2  = s_q.pin_s1;
    s_d.dll_rst = 1'b0;
    s_d.aref    = 1'b0;
    s_d.rd_v    = 1'b0;
    s_d.push_v  = 1'b0;
    s_d.lost    = s_q.push_v & ~wr_in.ready;
    s_d.buf_rdy = wr_in.ready;

    // Burst progress; one word per link edge
    if (beat) begin
      if (s_q.b_wr) begin
        s_d.push_v = 1'b1;
        s_d.push_w = {s_q.b_bank, burst_col(s_q.b_col, s_q.b_cnt, s_q.b_lm1, s_q.mode[dmcd_pkg::BT_POS]),
                      ~pins.mask, pins.dq};
      end else begin
        s_d.rd_v  = 1'b1;
        s_d.rd_bk = s_q.b_bank;
        s_d.rd_c  = burst_col(s_q.b_col, s_q.b_cnt, s_q.b_lm1, s_q.mode[dmcd_pkg::BT_POS]);
      end
      s_d.b_cnt = s_q.b_cnt + 3'h1;
      s_d.bst   = dmcd_pkg::BST_RUN;
      if (s_q.b_cnt == s_q.b_lm1) begin
        s_d.bst = dmcd_pkg::BST_IDLE;
        if (s_q.b_ap) begin
          s_d.banks[s_q.b_bank] = 1'b0;
        end
      end
    end else if (rise && s_q.bst == dmcd_pkg::BST_WAIT) begin
      s_d.b_wait = s_q.b_wait - 2'h1;
    end

    // Self refresh ends at the first edge with clock enable high
    if (rise && s_q.sref && pins.cke) begin
      s_d.sref   = 1'b0;
      s_d.dll_on = 1'b1;
    end

    // New command at the link edge; reserved cases change nothing
    if (rise && !s_q.sref) begin
      case (cmd)
        dmcd_pkg::DMCD_ACT: begin
          s_d.banks[pins.ba] = 1'b1;
        end
        dmcd_pkg::DMCD_RD, dmcd_pkg::DMCD_WR: begin
          if (bl_m1 != 3'h0 && (cmd == dmcd_pkg::DMCD_WR || lat_ok)) begin
            s_d.bst    = dmcd_pkg::BST_WAIT;
            s_d.b_wr   = (cmd == dmcd_pkg::DMCD_WR);
            s_d.b_ap   = pins.addr[dmcd_pkg::AP_POS];
            s_d.b_bank = pins.ba;
            s_d.b_col  = col_in;
            s_d.b_cnt  = 3'h0;
            s_d.b_lm1  = bl_m1;
            s_d.b_wait = (cmd == dmcd_pkg::DMCD_WR) ? dmcd_pkg::WR_WAIT : dmcd_pkg::RD_WAIT_FULL;
            s_d.rd_h   = s_q.mode[6];
          end
        end
        dmcd_pkg::DMCD_STOP: begin
          if (!s_q.b_wr && !s_q.b_ap) begin
            s_d.bst = dmcd_pkg::BST_IDLE;
          end
        end
        dmcd_pkg::DMCD_PRE: begin
          if (pins.addr[dmcd_pkg::AP_POS]) begin
            s_d.banks = 4'h0;
          end else begin
            s_d.banks[pins.ba] = 1'b0;
          end
        end
        dmcd_pkg::DMCD_REF: begin
          if (pins.cke) begin
            s_d.aref = 1'b1;
          end else begin
            s_d.sref = 1'b1;
          end
        end
        dmcd_pkg::DMCD_LMR: begin
          if (pins.ba == dmcd_pkg::BANK_SEL_BASE) begin
            if (opm == dmcd_pkg::OPM_NORMAL) begin
              s_d.mode = pins.addr;
            end else if (opm == dmcd_pkg::OPM_DLLRST) begin
              s_d.mode    = pins.addr;
              s_d.mode[dmcd_pkg::DLL_RST_POS] = 1'b0;
              s_d.dll_rst = 1'b1;
            end
          end else if (pins.ba == dmcd_pkg::BANK_SEL_EXT) begin
            s_d.ext    = pins.addr;
            s_d.dll_on = ~pins.addr[dmcd_pkg::DLL_DIS_POS];
          end
        end
        default: begin
        end
      endcase
    end

    // Output stage in front of the memory write port
    if (wr_out.ready) begin
      s_d.out_v = wr_out.valid;
      s_d.out_w = wr_out.data;
    end
  end

  // ----------------------------------------------------------------
  // State register; pins are resampled so reset holds no port values
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q        <= '0;
      s_q.mode   <= dmcd_pkg::MODE_RST;
      s_q.ext    <= dmcd_pkg::EXT_RST;
      s_q.dll_on <= 1'b1;
      s_q.bst    <= dmcd_pkg::BST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign mode_reg           = s_q.mode;
  assign ext_mode_reg       = s_q.ext;
  assign dll_enabled        = s_q.dll_on;
  assign dll_reset_pulse    = s_q.dll_rst;
  assign drive_reduced      = s_q.ext[dmcd_pkg::DRIVE_POS];
  assign bank_open          = s_q.banks;
  assign auto_refresh_pulse = s_q.aref;
  assign self_refresh       = s_q.sref;
  assign rd_beat            = s_q.rd_v;
  assign rd_half_clk        = s_q.rd_h;
  assign rd_bank            = s_q.rd_bk;
  assign rd_col             = s_q.rd_c;
  assign wr_buf_ready       = s_q.buf_rdy;
  assign wr_beat_lost       = s_q.lost;
  assign mem_wr_valid       = s_q.out_v;
  assign {mem_wr_bank, mem_wr_col, mem_wr_byte_en, mem_wr_data} = s_q.out_w;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence seq_lmr(logic [1:0] sel);
    rise && !s_q.sref && cmd == dmcd_pkg::DMCD_LMR && pins.ba == sel;
  endsequence
  sequence seq_rd_cmd;
    rise && !s_q.sref && cmd == dmcd_pkg::DMCD_RD && bl_m1 != 3'h0 && lat_ok;
  endsequence

  a_base_mode_load: assert property (seq_lmr(dmcd_pkg::BANK_SEL_BASE) ##0 opm == dmcd_pkg::OPM_NORMAL
    |=> mode_reg == $past(pins.addr)) else $error("base mode load not stored");
  a_dll_reset_clear: assert property (seq_lmr(dmcd_pkg::BANK_SEL_BASE) ##0 opm == dmcd_pkg::OPM_DLLRST
    |=> dll_reset_pulse && !mode_reg[dmcd_pkg::DLL_RST_POS] ##1 !dll_reset_pulse)
    else $error("dll reset not pulsed or bit kept");
  a_ext_mode_load: assert property (seq_lmr(dmcd_pkg::BANK_SEL_EXT)
    |=> ext_mode_reg == $past(pins.addr) && $stable(mode_reg)) else $error("extended load wrong");
  a_deselect_holds: assert property (rise && pins.cs_n && !beat
    |=> $stable(mode_reg) && $stable(ext_mode_reg) && $stable(bank_open)) else $error("deselect changed state");
  a_precharge_all: assert property (rise && !s_q.sref && cmd == dmcd_pkg::DMCD_PRE && pins.addr[dmcd_pkg::AP_POS]
    |=> bank_open == 4'h0) else $error("precharge all left a bank open");
  a_self_ref_entry: assert property (rise && !s_q.sref && cmd == dmcd_pkg::DMCD_REF && !pins.cke
    |=> self_refresh && !auto_refresh_pulse) else $error("self refresh not entered");
  a_self_ref_exit: assert property (rise && s_q.sref && pins.cke
    |=> !self_refresh && dll_enabled) else $error("dll not re-enabled on exit");
  a_read_latency: assert property (seq_rd_cmd |=> !rd_beat [*8] ##[17:40] rd_beat)
    else $error("first read data not near edge n plus latency");
  a_burst_in_block: assert property (beat && !s_q.b_wr
    |=> (rd_col & ~{8'h00, $past(s_q.b_lm1)}) == ($past(s_q.b_col) & ~{8'h00, $past(s_q.b_lm1)}))
    else $error("burst left its aligned block");
  a_mask_blocks: assert property (beat && s_q.b_wr
    |=> s_q.push_v && s_q.push_w[dmcd_pkg::DATA_W +: dmcd_pkg::MASK_W] == ~$past(pins.mask))
    else $error("write mask not applied");
endmodule // dmcd_decode

// File: src/dmcd_pkg.sv
// Shared constants and types for the mode and command decode block
package dmcd_pkg;
  // ----------------------------------------------------------------
  // Pin widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 64;
  localparam int MASK_W = 8;
  localparam int COL_W  = 11;
  localparam int WORD_W = 2 + COL_W + MASK_W + DATA_W;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int AP_POS        = 10;
  localparam int DLL_RST_POS   = 8;
  localparam int OPMODE_LO     = 7;
  localparam int BT_POS        = 3;
  localparam int LAT_LO        = 4;
  localparam int COL_HI_POS    = 11;
  localparam int DLL_DIS_POS   = 0;
  localparam int DRIVE_POS     = 1;
  localparam logic [1:0] BANK_SEL_BASE = 2'h0;
  localparam logic [1:0] BANK_SEL_EXT  = 2'h1;
  localparam logic [2:0] BL_TWO   = 3'h1;
  localparam logic [2:0] BL_FOUR  = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] LAT_TWO   = 3'h2;
  localparam logic [2:0] LAT_TWO_H = 3'h6;
  localparam logic [5:0] OPM_NORMAL = 6'h00;
  localparam logic [5:0] OPM_DLLRST = 6'h02;

  // ----------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] EXT_RST  = 13'h0000;
  localparam logic [1:0] RD_WAIT_FULL = 2'h2;
  localparam logic [1:0] WR_WAIT      = 2'h1;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DMCD_NO_OP, DMCD_ACT, DMCD_RD, DMCD_WR, DMCD_STOP, DMCD_PRE, DMCD_REF, DMCD_LMR
  } dmcd_cmd_t;

  typedef enum logic [1:0] {BST_IDLE, BST_WAIT, BST_RUN} dmcd_bst_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic [MASK_W-1:0] mask;
  } dmcd_pins_t;
endpackage

// File: src/dmcd_word_if.sv
// Valid/ready word channel between the decoder and its write buffer
`timescale 1ns/1ps
interface dmcd_word_if #(parameter int W = dmcd_pkg::WORD_W);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: src/dmcd_fifo.sv
// Small synchronous FIFO holding write beats
`timescale 1ns/1ps
module dmcd_fifo #(
  parameter int W     = dmcd_pkg::WORD_W,
  parameter int DEPTH = dmcd_pkg::FIFO_DEPTH
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  dmcd_word_if.snk  fill,
  dmcd_word_if.src  drain
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } dmcd_fifo_st_t;

  dmcd_fifo_st_t s_q;
  dmcd_fifo_st_t s_d;
  logic [W-1:0]  mem [DEPTH];
  logic          push;
  logic          pop;

  // ----------------------------------------------------------------
  // Handshakes; full and empty come straight from the count
  // ----------------------------------------------------------------
  assign fill.ready  = (s_q.cnt != (PW+1)'(DEPTH));
  assign drain.valid = (s_q.cnt != '0);
  assign drain.data  = mem[s_q.rp];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + PW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + PW'(1);
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[s_q.wp] <= fill.data;
    end
  end
endmodule // dmcd_fifo

// File: verification/dmcd_ctrl_model.sv
// Memory controller model: framed commands on a slow link clock
`timescale 1ns/1ps
module dmcd_ctrl_model (
  input  wire logic        ref_clk,
  output logic             link_clk,
  output logic [3:0]       strb_n,
  output logic             cke,
  output logic [1:0]       ba,
  output logic [12:0]      addr,
  output logic [63:0]      wdat,
  output logic [7:0]       mask
);
  // ----------------------------------------
  // Idle pins: deselected, link clock low
  // ----------------------------------------
  initial begin
    {link_clk, strb_n, cke, ba, addr, wdat, mask} = {1'b0, 4'hf, 1'b1, 87'h0};
  end

  // One command per frame; strobes are {cs, row, col, we}, all active low
  task automatic cmd(input logic [3:0] s, input logic [1:0] b, input logic [12:0] a, input logic ce,
                     input logic [63:0] d, input logic [7:0] m);
    @(posedge ref_clk);
    {link_clk, strb_n, cke, ba, addr, wdat, mask} <= {1'b0, s, ce, b, a, d, m};
    repeat (7) @(posedge ref_clk); // Eight low and eight high: 160 ns link period
    link_clk <= 1'b1;
    repeat (8) @(posedge ref_clk);
    link_clk <= 1'b0;
    // Released lines show the inverse, so stale values never pass
    {addr, wdat} <= {~a, ~d};
  endtask
endmodule // dmcd_ctrl_model

// File: verification/test_ddr_mode_and_command_decode.sv
// Self-checking bench for the mode and command decode block
`timescale 1ns/1ps
module test_ddr_mode_and_command_decode;
  localparam logic [3:0] NO_OP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4, STOP = 4'h6, PRE = 4'h2, REF = 4'h1, LMR = 4'h0;
  logic        ref_clk, sys_rst, mem_wr_ready, link_clk, cke, dll_en, dll_rp, drv, arp, sr, rd_beat, rd_half, mwv;
  logic [3:0]  s, bank_open;
  logic [1:0]  ba, rd_bank, mwb;
  logic [12:0] addr, mode_reg, ext_reg;
  logic [63:0] wd, mwd;
  logic [7:0]  wm, mwe;
  logic [10:0] rd_col, mwc;
  logic        wbr, lost;
  int          error_cnt, check_count, cyc, n_rst, n_arp, n_lost;
  logic [12:0] rq[$];
  logic [84:0] wq[$];

  dmcd_decode dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk), .chip_sel_n(s[3]),
    .row_strobe_n(s[2]), .col_strobe_n(s[1]), .write_en_n(s[0]), .clk_en(cke), .bank_sel_lo(ba[0]),
    .bank_sel_hi(ba[1]), .addr(addr), .wr_data(wd), .write_mask(wm), .mem_wr_ready(mem_wr_ready),
    .mode_reg(mode_reg), .ext_mode_reg(ext_reg), .dll_enabled(dll_en), .dll_reset_pulse(dll_rp),
    .drive_reduced(drv), .bank_open(bank_open), .auto_refresh_pulse(arp), .self_refresh(sr), .rd_beat(rd_beat),
    .rd_half_clk(rd_half), .rd_bank(rd_bank), .rd_col(rd_col), .wr_buf_ready(wbr), .wr_beat_lost(lost),
    .mem_wr_valid(mwv), .mem_wr_bank(mwb), .mem_wr_col(mwc), .mem_wr_byte_en(mwe), .mem_wr_data(mwd));
  dmcd_ctrl_model u_ctrl (.ref_clk(ref_clk), .link_clk(link_clk), .strb_n(s), .cke(cke), .ba(ba),
    .addr(addr), .wdat(wd), .mask(wm));

  // ----------------------------------------
  // Clock, timeout and output monitors
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Pulses stand one cycle, so they are counted here rather than polled
  always @(posedge ref_clk) begin
    cyc++;
    if (rd_beat === 1'b1) rq.push_back({rd_bank, rd_col});
    if (mwv === 1'b1 && mem_wr_ready === 1'b1) wq.push_back({mwb, mwc, mwe, mwd});
    if (dll_rp === 1'b1) n_rst++;
    if (arp === 1'b1) n_arp++;
    if (lost === 1'b1) n_lost++;
    if (cyc == 8000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [84:0] seen, input logic [84:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic c(input logic [3:0] cm, input logic [1:0] b, input logic [12:0] a);
    u_ctrl.cmd(cm, b, a, 1'b1, 64'h0, 8'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mode();
    c(LMR, 2'h0, 13'h0122);
    chk("dll_reset_pulses", n_rst, 1);
    chk("mode_reg", mode_reg, 13'h0022);
    c(LMR, 2'h0, 13'h0022);
    chk("mode_reg", mode_reg, 13'h0022);
    // Deselected load: reserved op modes are never sent
    u_ctrl.cmd(4'h8, 2'h0, 13'h0023, 1'b1, 64'h0, 8'h0);
    chk("mode_reg_deselect", mode_reg, 13'h0022);
    c(LMR, 2'h2, 13'h0003);
    chk("ext_reserved_bank", ext_reg, 13'h0000);
    c(LMR, 2'h1, 13'h0003);
    chk("ext_mode_reg", ext_reg, 13'h0003);
    chk("dll_enabled", dll_en, 0);
    chk("drive_reduced", drv, 1);
    u_ctrl.cmd(4'hc, 2'h1, 13'h0000, 1'b1, 64'h0, 8'h0);
    chk("ext_after_deselect", ext_reg, 13'h0003);
  endtask
  task automatic t_bank();
    c(ACT, 2'h2, 13'h0000);
    chk("bank_open", bank_open, 4'h4);
    c(ACT, 2'h0, 13'h0000);
    c(PRE, 2'h0, 13'h0000);
    chk("bank_open_one", bank_open, 4'h4);
    c(ACT, 2'h1, 13'h0000);
    c(PRE, 2'h0, 13'h0400);
    chk("bank_open_all", bank_open, 4'h0);
  endtask
  task automatic t_refresh();
    c(REF, 2'h0, 13'h0000);
    chk("auto_refresh", n_arp, 1);
    u_ctrl.cmd(REF, 2'h0, 13'h0000, 1'b0, 64'h0, 8'h0);
    chk("self_refresh", sr, 1);
    c(NO_OP, 2'h0, 13'h0000);
    chk("self_refresh_exit", sr, 0);
    chk("dll_after_exit", dll_en, 1);
    // DLL settle time before any read
    repeat (200) c(NO_OP, 2'h0, 13'h0000);
  endtask
  // Expected order is worked out from the column, length and type
  task automatic t_read(input logic [12:0] md, input logic [12:0] a, input int len, input logic ilv, input logic hf);
    logic [10:0] col;
    logic [2:0]  off;
    col = {a[11], a[9:0]};
    c(LMR, 2'h0, md);
    c(ACT, 2'h3, 13'h0000);
    rq.delete();
    c(RD, 2'h3, a);
    repeat (len + 1) c(NO_OP, 2'h0, 13'h0000);
    chk("read_beats", rq.size(), len);
    chk("half_clock", rd_half, hf);
    for (int k = 0; k < len && k < rq.size(); k++) begin
      off = ilv ? (col[2:0] ^ k[2:0]) : (col[2:0] + k[2:0]);
      chk("read_col", rq[k], {2'h3, (col & ~11'(len - 1)) | 11'(off & 3'(len - 1))});
    end
    // Banks closed so the next mode load is legal
    c(PRE, 2'h0, 13'h0400);
  endtask
  // Burst stop on a plain read cuts the burst short
  task automatic t_stop();
    c(ACT, 2'h3, 13'h0000);
    rq.delete();
    c(RD, 2'h3, 13'h0000);
    c(NO_OP, 2'h0, 13'h0000);
    c(STOP, 2'h0, 13'h0000);
    repeat (4) c(NO_OP, 2'h0, 13'h0000);
    chk("stopped_burst", rq.size() < 4, 1);
    c(PRE, 2'h0, 13'h0400);
  endtask
  task automatic t_write();
    c(LMR, 2'h0, 13'h0023);
    c(ACT, 2'h1, 13'h0000);
    @(posedge ref_clk) mem_wr_ready <= 1'b0;
    wq.delete();
    c(WR, 2'h1, 13'h0000);
    for (int k = 0; k < 8; k++) u_ctrl.cmd(NO_OP, 2'h0, 13'h0000, 1'b1, {8{k[7:0]}}, k == 0 ? 8'h0f : 8'h00);
    // Buffer plus output stage hold the first words; the rest are dropped
    chk("beats_lost", n_lost, 8 - dmcd_pkg::FIFO_DEPTH - 1);
    chk("buf_full", wbr, 0);
    @(posedge ref_clk) mem_wr_ready <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk("buf_free", wbr, 1);
    chk("write_count", wq.size(), dmcd_pkg::FIFO_DEPTH + 1);
    chk("masked_word", wq[0], {2'h1, 11'h000, 8'hf0, 64'h0});
    chk("open_word", wq[1], {2'h1, 11'h001, 8'hff, {8{8'h01}}});
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset held two cycles, then each scenario in turn
  initial begin
    sys_rst = 1'b1;
    mem_wr_ready = 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("mode_reset", mode_reg, 13'h0000);
    chk("dll_reset_value", dll_en, 1);
    t_mode();
    t_bank();
    t_refresh();
    t_read(13'h0023, 13'h000d, 8, 1'b0, 1'b0);
    t_read(13'h006b, 13'h0005, 8, 1'b1, 1'b1);
    t_read(13'h0022, 13'h0803, 4, 1'b0, 1'b0);
    t_stop();
    t_write();
    wrap_up();
  end
endmodule // test_ddr_mode_and_command_decode
